//--- design/cbp_regs.sv
// Purpose: pin config bytes 11 to 19 of a four-output clock buffer
// Assumes: byte port strobes come from the serial bus engine, one clock
// Notes:   read data one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "cbp_consts.svh"
module cbp_regs #(
  parameter logic [1:0] IMP_DEFAULT = `CBP_IMP_100
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_wr_en,
  input  wire logic                 i_rd_en,
  input  wire logic [7:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_pd_restore,
  input  wire logic [3:0]           i_enable_pin,
  input  wire logic                 i_power_good_powerdown_pin,
  output var  logic [7:0]           o_rdata,
  output var  logic                 o_rd_valid,
  output var  cbp_pkg::cbp_stop_t   o_stop_state_sel,
  output var  logic                 o_stop_true_level,
  output var  logic                 o_stop_comp_level,
  output var  logic                 o_stop_hiz,
  output logic      [1:0]           o_feedback_impedance_sel,
  output logic      [3:0][1:0]      o_out_impedance_sel,
  output var  logic [3:0][1:0]      o_enable_pin_pull_sel,
  output var  logic [1:0]           o_bandwidth_bypass_pull_sel,
  output var  logic [1:0]           o_power_good_pull_sel,
  output var  logic [3:0]           o_enable_pin_polarity,
  output var  logic                 o_powerdown_pin_polarity,
  output var  logic [3:0]           o_output_enabled,
  output var  logic                 o_power_down_state
);
  import cbp_pkg::*;

  // ------------------------------------------------------------------
  // next-state signals
  // ------------------------------------------------------------------
  cbp_stop_t       next_stop;
  logic            next_true;
  logic            next_comp;
  logic            next_hiz;
  logic [3:0][1:0] next_oe_pull;
  logic [1:0]      next_bw_pull;
  logic [1:0]      next_pg_pull;
  logic [3:0]      next_oe_pol;
  logic            next_pd_pol;
  logic [7:0]      next_rdata;
  logic            next_rd_valid;
  logic [3:0]      next_out_en;
  logic            next_pd;
  logic            pd_clear;
  logic [4:0]      imp_wr;
  logic [4:0][1:0] imp_wd;
  logic [4:0][1:0] imp_q;

  // clearing waits for the registered power-down state, so a glitch on the
  // pin wipes the configuration only if a clock edge samples it
  assign pd_clear = o_power_down_state && !i_pd_restore;

  // ------------------------------------------------------------------
  // impedance fields: feedback is entry 0, outputs are 1..4
  // ------------------------------------------------------------------
  always_comb begin
    imp_wr    = 5'h00;
    imp_wd[0] = i_wdata[7:6];
    imp_wd[1] = i_wdata[3:2];
    imp_wd[2] = i_wdata[7:6];
    imp_wd[3] = i_wdata[1:0];
    imp_wd[4] = i_wdata[5:4];
    if (i_wr_en && i_addr == `CBP_ADDR_STOP_FB) begin
      imp_wr[0] = 1'b1;
    end else if (i_wr_en && i_addr == `CBP_ADDR_IMP_A) begin
      imp_wr[2:1] = 2'h3;
    end else if (i_wr_en && i_addr == `CBP_ADDR_IMP_B) begin
      imp_wr[4:3] = 2'h3;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1) begin : g_imp
      cbp_imp_field #(.RST(IMP_DEFAULT)) u_field (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_wr     (imp_wr[k]),
        .i_wdata  (imp_wd[k]),
        .i_clear  (pd_clear),
        .o_sel    (imp_q[k])
      );
    end
  endgenerate

  assign o_feedback_impedance_sel = imp_q[0];
  assign o_out_impedance_sel      = imp_q[4:1];

  // ------------------------------------------------------------------
  // control fields, pin qualification and read port
  // ------------------------------------------------------------------
  always_comb begin
    next_stop     = o_stop_state_sel;
    next_oe_pull  = o_enable_pin_pull_sel;
    next_bw_pull  = o_bandwidth_bypass_pull_sel;
    next_pg_pull  = o_power_good_pull_sel;
    next_oe_pol   = o_enable_pin_polarity;
    next_pd_pol   = o_powerdown_pin_polarity;
    if (pd_clear) begin
      next_stop    = cbp_stop_t'(`CBP_STOP_RST);
      next_oe_pull = {4{`CBP_PULL_OE_RST}};
      next_bw_pull = `CBP_PULL_BW_RST;
      next_pg_pull = `CBP_PULL_PG_RST;
      next_oe_pol  = 4'h0;
      next_pd_pol  = 1'b0;
    end else if (i_wr_en) begin
      // reserved bits are dropped here; reads return fixed values for them, 01 in byte 15 bits 3:2
      if (i_addr == `CBP_ADDR_STOP_FB) begin
        next_stop = cbp_stop_t'(i_wdata[1:0]);
      end else if (i_addr == `CBP_ADDR_PULL_A) begin
        next_oe_pull[1] = i_wdata[7:6];
        next_oe_pull[0] = i_wdata[3:2];
      end else if (i_addr == `CBP_ADDR_PULL_B) begin
        next_oe_pull[3] = i_wdata[5:4];
        next_oe_pull[2] = i_wdata[1:0];
      end else if (i_addr == `CBP_ADDR_PULL_CTL) begin
        next_bw_pull = i_wdata[3:2];
        next_pg_pull = i_wdata[1:0];
      end else if (i_addr == `CBP_ADDR_OE_POL) begin
        next_oe_pol = {i_wdata[6], i_wdata[4], i_wdata[3], i_wdata[1]};
      end else if (i_addr == `CBP_ADDR_PD_POL) begin
        next_pd_pol = i_wdata[0];
      end
    end
    next_true = (o_stop_state_sel == CBP_STOP_HIGH_LOW);
    next_comp = (o_stop_state_sel == CBP_STOP_LOW_HIGH);
    next_hiz  = (o_stop_state_sel == CBP_STOP_HIZ);
    next_out_en = ~(i_enable_pin ^ o_enable_pin_polarity);
    next_pd     = ~(i_power_good_powerdown_pin ^ o_powerdown_pin_polarity);
    next_rd_valid = i_rd_en;
    next_rdata    = `CBP_RSVD_BYTE;
    if (i_addr == `CBP_ADDR_STOP_FB) begin
      next_rdata = {imp_q[0], 4'h0, o_stop_state_sel};
    end else if (i_addr == `CBP_ADDR_IMP_A) begin
      next_rdata = {imp_q[2], 2'h0, imp_q[1], 2'h0};
    end else if (i_addr == `CBP_ADDR_IMP_B) begin
      next_rdata = {2'h0, imp_q[4], 2'h0, imp_q[3]};
    end else if (i_addr == `CBP_ADDR_PULL_A) begin
      next_rdata = {o_enable_pin_pull_sel[1], 2'h0, o_enable_pin_pull_sel[0], 2'h0};
    end else if (i_addr == `CBP_ADDR_PULL_B) begin
      next_rdata = {2'h0, o_enable_pin_pull_sel[3], `CBP_PULL_B_RSVD,
                    o_enable_pin_pull_sel[2]};
    end else if (i_addr == `CBP_ADDR_PULL_CTL) begin
      next_rdata = {4'h0, o_bandwidth_bypass_pull_sel, o_power_good_pull_sel};
    end else if (i_addr == `CBP_ADDR_OE_POL) begin
      next_rdata = {1'b0, o_enable_pin_polarity[3], 1'b0, o_enable_pin_polarity[2],
                    o_enable_pin_polarity[1], 1'b0, o_enable_pin_polarity[0], 1'b0};
    end else if (i_addr == `CBP_ADDR_PD_POL) begin
      next_rdata = {7'h00, o_powerdown_pin_polarity};
    end
    if (!i_rd_en) begin
      next_rdata = o_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_stop_state_sel            <= cbp_stop_t'(`CBP_STOP_RST);
      o_enable_pin_pull_sel       <= {4{`CBP_PULL_OE_RST}};
      o_bandwidth_bypass_pull_sel <= `CBP_PULL_BW_RST;
      o_power_good_pull_sel       <= `CBP_PULL_PG_RST;
      o_enable_pin_polarity       <= 4'h0;
      o_powerdown_pin_polarity    <= 1'b0;
      o_stop_true_level           <= 1'b0;
      o_stop_comp_level           <= 1'b0;
      o_stop_hiz                  <= 1'b0;
      o_output_enabled            <= 4'h0;
      o_power_down_state          <= 1'b0;
      o_rdata                     <= 8'h00;
      o_rd_valid                  <= 1'b0;
    end else begin
      o_stop_state_sel            <= next_stop;
      o_enable_pin_pull_sel       <= next_oe_pull;
      o_bandwidth_bypass_pull_sel <= next_bw_pull;
      o_power_good_pull_sel       <= next_pg_pull;
      o_enable_pin_polarity       <= next_oe_pol;
      o_powerdown_pin_polarity    <= next_pd_pol;
      o_stop_true_level           <= next_true;
      o_stop_comp_level           <= next_comp;
      o_stop_hiz                  <= next_hiz;
      o_output_enabled            <= next_out_en;
      o_power_down_state          <= next_pd;
      o_rdata                     <= next_rdata;
      o_rd_valid                  <= next_rd_valid;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_stop_decode;
    (o_stop_state_sel == CBP_STOP_LOW_HIGH) |=> (o_stop_comp_level && !o_stop_true_level
                                                 && !o_stop_hiz);
  endproperty
  a_stop_decode: assert property (p_stop_decode) else $error("stop drive decode wrong");

  property p_stop_write;
    (i_wr_en && !pd_clear && i_addr == `CBP_ADDR_STOP_FB) |=> ##1
      (o_stop_hiz == ($past(i_wdata[1:0], 2) == 2'h1));
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stop write not applied");

  property p_fb_write;
    (i_wr_en && !pd_clear && i_addr == `CBP_ADDR_STOP_FB && i_wdata[7:6] != `CBP_IMP_RSVD)
      |=> (o_feedback_impedance_sel == $past(i_wdata[7:6]));
  endproperty
  a_fb_write: assert property (p_fb_write) else $error("feedback impedance not written");

  property p_imp_b_write;
    (i_wr_en && !pd_clear && i_addr == `CBP_ADDR_IMP_B && i_wdata[5:4] != `CBP_IMP_RSVD)
      |=> (o_out_impedance_sel[3] == $past(i_wdata[5:4]));
  endproperty
  a_imp_b_write: assert property (p_imp_b_write) else $error("output impedance not written");

  property p_reset_defaults;
    @(posedge i_clk) disable iff (1'b0)
    !i_resetn |=> (o_out_impedance_sel[0] == IMP_DEFAULT
                   && o_enable_pin_pull_sel[2] == `CBP_PULL_OE_RST
                   && o_bandwidth_bypass_pull_sel == `CBP_PULL_BW_RST
                   && o_power_good_pull_sel == `CBP_PULL_PG_RST);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset default");

  property p_pull_write;
    (i_wr_en && !pd_clear && i_addr == `CBP_ADDR_PULL_A)
      |=> (o_enable_pin_pull_sel[1] == $past(i_wdata[7:6]));
  endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull select not written");

  property p_enable_polarity;
    1'b1 |=> (o_output_enabled == $past(~(i_enable_pin ^ o_enable_pin_polarity)));
  endproperty
  a_enable_polarity: assert property (p_enable_polarity) else $error("enable polarity wrong");

  property p_pd_polarity;
    (i_power_good_powerdown_pin == o_powerdown_pin_polarity) |=> o_power_down_state;
  endproperty
  a_pd_polarity: assert property (p_pd_polarity) else $error("power-down polarity wrong");

  property p_pd_clear;
    (o_power_down_state && !i_pd_restore) |=> (o_enable_pin_polarity == 4'h0
                                             && o_out_impedance_sel[2] == IMP_DEFAULT);
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("config kept in power-down");

  property p_pd_keep;
    (o_power_down_state && i_pd_restore && !i_wr_en) |=> $stable(o_enable_pin_pull_sel);
  endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("config lost in power-down");

  property p_rsvd_read;
    (i_rd_en && i_addr == `CBP_ADDR_RSVD17) |=> (o_rd_valid && o_rdata == 8'h00);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte reads nonzero");

  property p_rsvd_bit_read;
    (i_rd_en && i_addr == `CBP_ADDR_PULL_B) |=> (o_rdata[3:2] == `CBP_PULL_B_RSVD);
  endproperty
  a_rsvd_bit_read: assert property (p_rsvd_bit_read) else $error("reserved bits wrong");

  c_hiz_stop:   cover property (o_stop_hiz);
  c_pd_clear:   cover property (o_power_down_state && !i_pd_restore);
  c_pol_high:   cover property (o_enable_pin_polarity == 4'hF && o_output_enabled == 4'hF);
  c_read_back:  cover property (o_rd_valid && o_rdata != 8'h00);
endmodule : cbp_regs
`default_nettype wire

//--- design/cbp_consts.svh
// Purpose: offsets, field positions, reset values of the pin config bytes
// Assumes: byte-wide register port, addresses are the byte numbers
// Notes:   definitions only
// Operation
// - stop-state field, byte 11 bits 1:0, sets disabled output drive; default 00.
// - feedback impedance field, byte 11 bits 7:6: 33, 85, 100 ohm; 11 reserved.
// - four output impedance fields in bytes 12 and 13, same encoding.
// - impedance fields power up at a variant-dependent default (10 or 01).
// - bytes 14 to 16 hold two-bit pull selects per control pin.
// - enable pins default pull-down, bandwidth pin both, power-good pin pull-up.
// - byte 18 polarity bit per enable pin; 0 enables on low, 1 on high.
// - byte 19 bit 0: 0 powers down on low pin, 1 on high.
// - restore bit 1 keeps configuration in power-down; 0 clears it.
`ifndef CBP_CONSTS_SVH
`define CBP_CONSTS_SVH

// ------------------------------------------------------------------
// byte addresses
// ------------------------------------------------------------------
`define CBP_ADDR_STOP_FB   8'h0B
`define CBP_ADDR_IMP_A     8'h0C
`define CBP_ADDR_IMP_B     8'h0D
`define CBP_ADDR_PULL_A    8'h0E
`define CBP_ADDR_PULL_B    8'h0F
`define CBP_ADDR_PULL_CTL  8'h10
`define CBP_ADDR_RSVD17    8'h11
`define CBP_ADDR_OE_POL    8'h12
`define CBP_ADDR_PD_POL    8'h13

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define CBP_IMP_RSVD       2'h3
`define CBP_IMP_100        2'h2
`define CBP_IMP_85         2'h1
`define CBP_STOP_RST       2'h0
`define CBP_PULL_OE_RST    2'h1
`define CBP_PULL_BW_RST    2'h3
`define CBP_PULL_PG_RST    2'h2
`define CBP_PULL_B_RSVD    2'h1
`define CBP_RSVD_BYTE      8'h00

`endif

//--- design/cbp_pkg.sv
// Purpose: types of the pin config register bank
// Assumes: nothing
// Notes:   encodings as the field values
package cbp_pkg;
  typedef enum logic [1:0] {
    CBP_STOP_LOW_LOW  = 2'h0,
    CBP_STOP_HIZ      = 2'h1,
    CBP_STOP_HIGH_LOW = 2'h2,
    CBP_STOP_LOW_HIGH = 2'h3
  } cbp_stop_t;
endpackage : cbp_pkg

//--- design/cbp_imp_field.sv
// Purpose: one two-bit output impedance select
// Assumes: write strobe already decoded
// Notes:   reserved code is refused, field keeps its value
`timescale 1ns/10ps
`default_nettype none
`include "cbp_consts.svh"
module cbp_imp_field #(
  parameter logic [1:0] RST = `CBP_IMP_100
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_wr,
  input  wire logic [1:0] i_wdata,
  input  wire logic       i_clear,
  output var  logic [1:0] o_sel
);
  import cbp_pkg::*;
  logic [1:0] next_sel;

  always_comb begin
    next_sel = o_sel;
    if (i_clear) begin
      next_sel = RST;
    end else if (i_wr && (i_wdata != `CBP_IMP_RSVD)) begin
      next_sel = i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_sel <= RST;
    end else begin
      o_sel <= next_sel;
    end
  end

  property p_rsvd_refused;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_wr && !i_clear && i_wdata == `CBP_IMP_RSVD) |=> $stable(o_sel);
  endproperty
  a_rsvd_refused: assert property (p_rsvd_refused) else $error("reserved impedance stored");
endmodule : cbp_imp_field
`default_nettype wire

//--- tb/cbp_host.sv
// Purpose: register-port host that configures the pin config bank
// Assumes: strobes launched on a rising edge, one byte per strobe
// Notes:   idle address and data are scrambled so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module cbp_host (
  input  wire logic       i_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_wr_en,
  output var  logic       o_rd_en,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // ------------------------------------------------------------------
  // byte transfers
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr

  // answer awaited a few cycles only, ok low means no answer came
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr  <= ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
      end else
        @(posedge i_clk);
    end
  endtask : rd
endmodule : cbp_host
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench of the pin config bank against a byte model
// Assumes: 100-ohm variant default, one clock
// Notes:   power-down restore kept high except in the clear scenario
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cbp_pkg::*;
  localparam logic [1:0] IMP = 2'h2;
  logic             clk, resetn, wr_en, rd_en, rd_valid, pd_restore, pg_pin, ok;
  logic             t_lvl, c_lvl, hiz, pd_pol, pd_state;
  logic [7:0]       addr, wdata, rdata, d;
  logic [3:0]       oe_pin, oe_pol, oe_en;
  logic [1:0]       feedback_impedance_sel, bw_pull, pg_pull;
  logic [3:0][1:0]  out_imp, oe_pull;
  cbp_stop_t        stop_sel;
  logic [7:0]       exp_q [0:31];
  int               mismatches, n_checks, seed, a;

  always #4 clk = ~clk;

  cbp_regs #(.IMP_DEFAULT(IMP)) uut (
    .i_clk(clk), .i_resetn(resetn), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
    .i_wdata(wdata), .i_pd_restore(pd_restore), .i_enable_pin(oe_pin),
    .i_power_good_powerdown_pin(pg_pin), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_stop_state_sel(stop_sel), .o_stop_true_level(t_lvl), .o_stop_comp_level(c_lvl),
    .o_stop_hiz(hiz), .o_feedback_impedance_sel(feedback_impedance_sel), .o_out_impedance_sel(out_imp),
    .o_enable_pin_pull_sel(oe_pull), .o_bandwidth_bypass_pull_sel(bw_pull),
    .o_power_good_pull_sel(pg_pull), .o_enable_pin_polarity(oe_pol),
    .o_powerdown_pin_polarity(pd_pol), .o_output_enabled(oe_en), .o_power_down_state(pd_state));

  cbp_host host (.i_clk(clk), .i_rd_valid(rd_valid), .i_rdata(rdata), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  // ------------------------------------------------------------------
  // byte model
  // ------------------------------------------------------------------
  function automatic logic [7:0] rst_val(input int b);
    case (b)
      11: return {IMP, 6'h00};
      12: return {IMP, 2'h0, IMP, 2'h0};
      13: return {2'h0, IMP, 2'h0, IMP};
      14: return 8'h44;
      15: return 8'h15;
      16: return 8'h0E;
      default: return 8'h00;
    endcase
  endfunction : rst_val

  function automatic logic [7:0] wmask(input int b);
    case (b)
      11: return 8'hC3;
      12, 14: return 8'hCC;
      13, 15: return 8'h33;
      16: return 8'h0F;
      18: return 8'h5A;
      19: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction : wmask

  task automatic mreset();
    for (int b = 0; b < 32; b++) exp_q[b] = rst_val(b);
  endtask : mreset

  // impedance code 11 leaves the field alone, the stop field takes all codes
  task automatic wr_both(input int b, input logic [7:0] v);
    logic [7:0] m;
    m = wmask(b);
    for (int k = 0; k < 4; k++)
      if (v[2*k+:2] == 2'h3 && (b == 12 || b == 13 || (b == 11 && k == 3))) m[2*k+:2] = 2'h0;
    exp_q[b] = (exp_q[b] & ~m) | (v & m);
    host.wr(8'(b), v);
  endtask : wr_both

  // ------------------------------------------------------------------
  // comparisons and closing
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic check_reg(input int b);
    host.rd(8'(b), d, ok);
    if (!ok) begin
      mismatches++;
      $display("Error at %0t: no read answer", $time);
      report_and_stop();
    end
    chk(d, exp_q[b]);
  endtask : check_reg

  task automatic check_ports();
    logic [7:0] e;
    repeat (2) @(posedge clk);
    #1;
    e = exp_q[11];
    chk({feedback_impedance_sel, hiz, c_lvl, t_lvl, 1'b0, stop_sel},
        {e[7:6], e[1:0] == 2'h1, e[1:0] == 2'h3, e[1:0] == 2'h2, 1'b0, e[1:0]});
    chk(out_imp, {exp_q[13][5:4], exp_q[13][1:0], exp_q[12][7:6], exp_q[12][3:2]});
    chk(oe_pull, {exp_q[15][5:4], exp_q[15][1:0], exp_q[14][7:6], exp_q[14][3:2]});
    e = exp_q[18];
    chk({bw_pull, pg_pull, oe_pol}, {exp_q[16][3:0], e[6], e[4], e[3], e[1]});
    chk({3'h0, pd_pol, oe_en}, {3'h0, exp_q[19][0], ~(oe_pin ^ {e[6], e[4], e[3], e[1]})});
    chk({7'h00, pd_state}, {7'h00, ~(pg_pin ^ exp_q[19][0])});
  endtask : check_ports

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 74;
    mismatches = 0;
    n_checks = 0;
    clk = 1'b0;
    resetn = 1'b0;
    pd_restore = 1'b1;
    oe_pin = 4'h0;
    pg_pin = 1'b1;
    mreset();
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    for (int b = 10; b < 21; b++) check_reg(b);
    check_ports();
    $display("test reset values done");
    for (int v = 0; v < 4; v++) begin
      for (int b = 11; b < 20; b++) wr_both(b, {4{2'(v)}});
      @(posedge clk);
      oe_pin <= 4'(v * 5);
      pg_pin <= v[1];
      for (int b = 11; b < 20; b++) check_reg(b);
      check_ports();
    end
    $display("test all field codes done");
    for (int i = 0; i < 200; i++) begin
      a = 10 + $unsigned($random(seed)) % 11;
      wr_both(a, 8'($random(seed)));
      @(posedge clk);
      oe_pin <= 4'($random(seed));
      pg_pin <= 1'($random(seed));
      check_reg(10 + $unsigned($random(seed)) % 11);
      if (i % 20 == 0) check_ports();
    end
    $display("test random traffic done");
    wr_both(19, 8'h00);
    @(posedge clk);
    pd_restore <= 1'b0;
    pg_pin <= 1'b0;
    repeat (3) @(posedge clk);
    mreset();
    host.wr(8'h12, 8'h5A);
    @(posedge clk);
    pg_pin <= 1'b1;
    repeat (3) @(posedge clk);
    for (int b = 11; b < 20; b++) check_reg(b);
    check_ports();
    @(posedge clk);
    pd_restore <= 1'b1;
    pg_pin <= 1'b0;
    wr_both(18, 8'h5A);
    repeat (3) @(posedge clk);
    check_reg(18);
    check_reg(12);
    $display("test power-down clear and keep done");
    // reset again after traffic: every written byte must fall back to its default
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    mreset();
    for (int b = 10; b < 21; b++) check_reg(b);
    check_ports();
    $display("test reset after traffic done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
